// File: src/sep_pkg.sv
// shared constants, states and carriers for the serial memory pin interface
package sep_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int WORD_AW = 8;
  localparam int BYTE_AW = WORD_AW + 1;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int OP_W = 2;
  localparam int CNT_W = 5;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRALL = 2'h1;
  localparam logic [1:0] EXT_ERALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int PROG_TIME_US = 3000;
  localparam int ALL_TIME_US = 8000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ALL_CYCLES = ALL_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {K_WRITE = 2'h0, K_ERASE = 2'h1, K_WRALL = 2'h2, K_ERALL = 2'h3} sep_kind_type;
  typedef enum logic [5:0] {
    L_IDLE = 6'h01, L_OP = 6'h02, L_ADDR = 6'h04, L_DATA = 6'h08, L_READ = 6'h10, L_DONE = 6'h20
  } sep_link_type;
  typedef enum logic [2:0] {E_IDLE = 3'h1, E_PROG = 3'h2, E_WALK = 3'h4} sep_eng_type;
  typedef struct packed {
    sep_kind_type kind;
    logic x8;
    logic [BYTE_AW-1:0] addr;
    logic [WORD_W-1:0] data;
  } sep_cmd_type;

endpackage

// File: src/sep_pin_if.sv
// serial memory pin interface: link shifter, command buffer, self-timed array
`timescale 1ns/10ps
module sep_pin_if #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES,
  parameter int ALL_CYCLES = sep_pkg::ALL_CYCLES,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic chip_select,
  input wire logic serial_in,
  input wire logic word_width_select,
  input wire logic program_allow,
  output logic serial_out,
  output logic serial_out_en
);
  import sep_pkg::*;

  localparam int PW = $clog2(BUF_DEPTH);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (BUF_DEPTH < 2 || (1 << PW) != BUF_DEPTH) begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two, at least 2");
  end
  if (PROG_CYCLES < 1 || ALL_CYCLES < 1) begin : g_bad_time
    $error("programming times must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // storage array
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:(1<<WORD_AW)-1];
  logic mem_we;
  logic [WORD_AW-1:0] mem_widx;
  logic [WORD_W-1:0] mem_wdata;

  // read port used by the link only while the engine is idle, so the word is static
  function automatic logic [WORD_W-1:0] rd_word(input logic [BYTE_AW-1:0] a, input logic wide);
    logic [WORD_W-1:0] w;
    w = mem[wide ? a[WORD_AW-1:0] : a[BYTE_AW-1:1]];
    if (wide) begin
      return w;
    end
    return {(a[0] ? w[15:8] : w[7:0]), ZERO_BYTE};
  endfunction

  // ---------------------------------------------------------------
  // link domain: instruction shifter
  // ---------------------------------------------------------------
  logic link_rst_n;
  sep_link_type lst_q, lst_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [OP_W-1:0] op_q, op_d;
  logic [BYTE_AW-1:0] addr_q, addr_d, addr_nx;
  logic [WORD_W-1:0] sh_q, sh_d, sh_nx;
  logic obit_q, obit_d;
  logic rdrv_q, rdrv_d;
  logic stat_q, stat_d;
  logic issue, wen_set, wen_clr;
  sep_cmd_type issue_cmd;
  logic [1:0] ext;
  logic [CNT_W-1:0] alen, dlen;
  logic busy_l;
  logic x16;

  // link state, settings and crossings kept through deselect
  logic wen_q, wen_d;
  logic req_q, req_d;
  sep_cmd_type cmd_q, cmd_d;
  logic w16_s1_q, w16_s2_q;
  logic ack_s1_q, ack_s2_q;
  logic ack_q;

  // deselect holds the shifter in reset, so edges meanwhile are ignored
  assign link_rst_n = resetn & chip_select;
  assign x16 = w16_s2_q;
  assign busy_l = req_q ^ ack_s2_q;
  assign alen = x16 ? CNT_W'(WORD_AW) : CNT_W'(BYTE_AW);
  assign dlen = x16 ? CNT_W'(WORD_W) : CNT_W'(BYTE_W);

  always_comb begin
    lst_d = lst_q;
    cnt_d = cnt_q;
    op_d = op_q;
    addr_d = addr_q;
    sh_d = sh_q;
    obit_d = obit_q;
    rdrv_d = rdrv_q;
    stat_d = stat_q;
    issue = 1'b0;
    wen_set = 1'b0;
    wen_clr = 1'b0;
    addr_nx = {addr_q[BYTE_AW-2:0], serial_in};
    sh_nx = {sh_q[WORD_W-2:0], serial_in};
    ext = x16 ? addr_nx[WORD_AW-1 -: 2] : addr_nx[BYTE_AW-1 -: 2];
    issue_cmd.kind = K_ERASE;
    issue_cmd.x8 = ~x16;
    issue_cmd.addr = addr_nx;
    issue_cmd.data = ERASED_WORD;
    unique case (lst_q)
      L_IDLE: begin
        // low input: edges pass with no effect
        if (serial_in) begin
          lst_d = L_OP;
          cnt_d = '0;
          stat_d = 1'b0;
          rdrv_d = 1'b0;
        end
      end
      L_OP: begin
        op_d = {op_q[0], serial_in};
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(OP_W - 1)) begin
          lst_d = L_ADDR;
          cnt_d = '0;
        end
      end
      L_ADDR: begin
        addr_d = addr_nx;
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == alen - CNT_W'(1)) begin
          cnt_d = '0;
          lst_d = L_DONE;
          unique case (op_q)
            OP_READ: begin
              // a read during programming is refused; status stays on the pin
              if (!busy_l) begin
                lst_d = L_READ;
                rdrv_d = 1'b1;
                obit_d = 1'b0;
                sh_d = rd_word(addr_nx, x16);
              end else begin
                stat_d = 1'b1;
              end
            end
            OP_WRITE: lst_d = L_DATA;
            OP_ERASE: begin
              issue = wen_q & ~busy_l;
              stat_d = 1'b1;
            end
            OP_EXT: begin
              unique case (ext)
                EXT_ENABLE: wen_set = 1'b1;
                EXT_DISABLE: wen_clr = 1'b1;
                EXT_ERALL: begin
                  issue_cmd.kind = K_ERALL;
                  issue = wen_q & ~busy_l;
                  stat_d = 1'b1;
                end
                EXT_WRALL: lst_d = L_DATA;
              endcase
            end
          endcase
        end
      end
      L_DATA: begin
        sh_d = sh_nx;
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == dlen - CNT_W'(1)) begin
          lst_d = L_DONE;
          cnt_d = '0;
          issue_cmd.kind = (op_q == OP_WRITE) ? K_WRITE : K_WRALL;
          issue_cmd.addr = addr_q;
          issue_cmd.data = x16 ? sh_nx : {ZERO_BYTE, sh_nx[BYTE_W-1:0]};
          issue = wen_q & ~busy_l;
          stat_d = 1'b1;
        end
      end
      L_READ: begin
        obit_d = sh_q[WORD_W-1];
        sh_d = {sh_q[WORD_W-2:0], 1'b0};
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == dlen - CNT_W'(1)) begin
          // sequential read: next location follows with no dummy bit
          cnt_d = '0;
          addr_d = addr_q + BYTE_AW'(1);
          sh_d = rd_word(addr_q + BYTE_AW'(1), x16);
        end
      end
      L_DONE: begin
        lst_d = L_DONE;
      end
      default: lst_d = L_IDLE;
    endcase
  end

  always_ff @(posedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lst_q <= L_IDLE;
      cnt_q <= '0;
      op_q <= '0;
      addr_q <= '0;
      sh_q <= '0;
      obit_q <= 1'b0;
      rdrv_q <= 1'b0;
      stat_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      addr_q <= addr_d;
      sh_q <= sh_d;
      obit_q <= obit_d;
      rdrv_q <= rdrv_d;
      stat_q <= stat_d;
    end
  end

  always_comb begin
    wen_d = wen_q;
    if (wen_set) begin
      wen_d = 1'b1;
    end else if (wen_clr) begin
      wen_d = 1'b0;
    end
    req_d = req_q ^ issue;
    cmd_d = issue ? issue_cmd : cmd_q;
  end

  // strap reset value 1 matches the pull-up default
  always_ff @(posedge serial_clock or negedge resetn) begin
    if (!resetn) begin
      wen_q <= 1'b0;
      req_q <= 1'b0;
      cmd_q <= '0;
      w16_s1_q <= 1'b1;
      w16_s2_q <= 1'b1;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      wen_q <= wen_d;
      req_q <= req_d;
      cmd_q <= cmd_d;
      w16_s1_q <= word_width_select;
      w16_s2_q <= w16_s1_q;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // system clock domain: crossing and command buffer
  // ---------------------------------------------------------------
  logic req_s1_q, req_s2_q, req_s3_q;
  logic pa_s1_q, pa_s2_q;
  logic pend_q, pend_d;
  logic rx_evt, push, pop, buf_ready, buf_valid;
  sep_cmd_type buf_q [0:BUF_DEPTH-1];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] fill_q, fill_d;

  // cmd_q is held stable until the ack returns, so it is safe to sample here
  assign rx_evt = req_s2_q ^ req_s3_q;
  assign buf_ready = fill_q != (PW+1)'(BUF_DEPTH);
  assign buf_valid = fill_q != '0;
  assign push = pend_q & buf_ready;

  always_comb begin
    pend_d = rx_evt | (pend_q & ~push);
    wp_d = push ? wp_q + PW'(1) : wp_q;
    rp_d = pop ? rp_q + PW'(1) : rp_q;
    fill_d = fill_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      pa_s1_q <= 1'b1;
      pa_s2_q <= 1'b1;
      pend_q <= 1'b0;
      wp_q <= '0;
      rp_q <= '0;
      fill_q <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      pa_s1_q <= program_allow;
      pa_s2_q <= pa_s1_q;
      pend_q <= pend_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      fill_q <= fill_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      buf_q[wp_q] <= cmd_q;
    end
  end

  // ---------------------------------------------------------------
  // system clock domain: self-timed programming engine
  // ---------------------------------------------------------------
  sep_eng_type est_q, est_d;
  logic [31:0] tmr_q, tmr_d;
  sep_cmd_type cur_q, cur_d;
  logic [WORD_AW-1:0] walk_q, walk_d;
  logic ack_d, ready_q, ready_d;
  logic [WORD_W-1:0] old_w;
  logic cur_all;

  assign pop = buf_valid & (est_q == E_IDLE);
  assign cur_all = (cur_q.kind == K_WRALL) || (cur_q.kind == K_ERALL);
  assign old_w = mem[mem_widx];

  always_comb begin
    est_d = est_q;
    tmr_d = tmr_q;
    cur_d = cur_q;
    walk_d = walk_q;
    ack_d = ack_q;
    mem_we = 1'b0;
    mem_widx = cur_q.x8 ? cur_q.addr[BYTE_AW-1:1] : cur_q.addr[WORD_AW-1:0];
    mem_wdata = cur_q.data;
    if (cur_q.x8) begin
      mem_wdata = cur_q.addr[0] ? {cur_q.data[7:0], old_w[7:0]} : {old_w[15:8], cur_q.data[7:0]};
    end
    unique case (est_q)
      E_IDLE: begin
        if (pop) begin
          cur_d = buf_q[rp_q];
          if (pa_s2_q) begin
            est_d = E_PROG;
            tmr_d = (cur_d.kind == K_WRALL || cur_d.kind == K_ERALL) ? 32'(ALL_CYCLES - 1) : 32'(PROG_CYCLES - 1);
          end else begin
            ack_d = ~ack_q;
          end
        end
      end
      E_PROG: begin
        tmr_d = tmr_q - 32'(1);
        if (tmr_q == '0) begin
          if (cur_all) begin
            est_d = E_WALK;
            walk_d = '0;
          end else begin
            mem_we = 1'b1;
            ack_d = ~ack_q;
            est_d = E_IDLE;
          end
        end
      end
      E_WALK: begin
        mem_we = 1'b1;
        mem_widx = walk_q;
        mem_wdata = cur_q.x8 ? {2{cur_q.data[7:0]}} : cur_q.data;
        walk_d = walk_q + WORD_AW'(1);
        if (walk_q == '1) begin
          ack_d = ~ack_q;
          est_d = E_IDLE;
        end
      end
      default: est_d = E_IDLE;
    endcase
    ready_d = (est_d == E_IDLE) & ~buf_valid & ~pend_d;
  end

  // engine ignores chip select, so a started cycle always completes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      est_q <= E_IDLE;
      tmr_q <= '0;
      cur_q <= '0;
      walk_q <= '0;
      ack_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      est_q <= est_d;
      tmr_q <= tmr_d;
      cur_q <= cur_d;
      walk_q <= walk_d;
      ack_q <= ack_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_widx] <= mem_wdata;
    end
  end

  // ---------------------------------------------------------------
  // serial output pin
  // ---------------------------------------------------------------
  logic show_status;
  logic cs_s1_q, cs_s2_q;
  logic hold_q, hold_d;

  // busy seen while selected keeps status on the pin after the cycle ends, until a start bit
  assign hold_d = cs_s2_q & (hold_q | ~ready_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_s1_q <= 1'h0;
      cs_s2_q <= 1'h0;
      hold_q <= 1'h0;
    end else begin
      cs_s1_q <= chip_select;
      cs_s2_q <= cs_s1_q;
      hold_q <= hold_d;
    end
  end

  // status level comes straight from the engine; it may move between serial edges
  assign show_status = stat_q | ((~ready_q | hold_q) & (lst_q == L_IDLE));
  assign serial_out = show_status ? ready_q : obit_q;
  assign serial_out_en = chip_select & (rdrv_q | show_status);

endmodule // sep_pin_if

// File: test/sep_pin_if_chk.sv
// port checker for the serial memory pin interface
`timescale 1ns/10ps
module sep_pin_if_chk import sep_pkg::*; #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic chip_select,
  input wire logic serial_in,
  input wire logic word_width_select,
  input wire logic program_allow,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  // margin covers the crossing back into the system clock
  localparam int BUSY_MAX = PROG_CYCLES + 8;
  // ---------------------------------------------------------------
  // link shadow, cleared with every deselect
  // ---------------------------------------------------------------
  logic started_q;
  logic show_q;
  logic [4:0] n_q;
  logic [1:0] op_q;
  logic [4:0] last_addr;
  logic rd_phase;
  // flips on every serial rise; n_q saturates, so it cannot mark edges in a long read
  logic tgl_q;
  assign last_addr = word_width_select ? 5'h0A : 5'h0B;
  assign rd_phase = started_q && op_q == OP_READ && n_q > last_addr;
  always_ff @(posedge serial_clock or negedge chip_select) begin
    if (!chip_select) begin
      started_q <= 1'h0;
      show_q <= 1'h0;
      n_q <= 5'h00;
      op_q <= 2'h0;
      tgl_q <= 1'h0;
    end else begin
      tgl_q <= ~tgl_q;
      if (serial_in) started_q <= 1'h1;
      if (started_q || serial_in) n_q <= (n_q == 5'h1F) ? n_q : n_q + 5'h01;
      if (started_q && n_q < 5'h03) op_q <= {op_q[0], serial_in};
      if (started_q && op_q == OP_WRITE && n_q == (word_width_select ? 5'h1A : 5'h13)) show_q <= 1'h1;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence rd_addr_done;
    started_q && op_q == OP_READ && n_q == last_addr;
  endsequence
  sequence idle_sel;
    !started_q && chip_select && !serial_in && !serial_out_en;
  endsequence
  sequence desel_then_quiet;
    !chip_select ##1 (chip_select && !serial_in);
  endsequence
  chk_desel_release: assert property (
    @(posedge clk) disable iff (!resetn) !chip_select |-> !serial_out_en) else $error("pin driven while deselected");
  chk_dummy_zero: assert property (
    @(posedge serial_clock) disable iff (!resetn) rd_addr_done |=> serial_out_en && !serial_out)
    else $error("no dummy zero before read data");
  chk_idle_quiet: assert property (
    @(posedge serial_clock) disable iff (!resetn) idle_sel |=> !serial_out_en) else $error("output before start");
  chk_link_desel: assert property (
    @(posedge serial_clock) disable iff (!resetn) desel_then_quiet |-> !serial_out_en)
    else $error("deselected edges had an effect");
  chk_busy_bounded: assert property (
    @(posedge clk) disable iff (!resetn) show_q && serial_out_en && !serial_out
      |-> ##[1:BUSY_MAX] (serial_out || !chip_select)) else $error("busy too long");
  chk_status_held: assert property (
    @(posedge clk) disable iff (!resetn) show_q && chip_select |-> serial_out_en) else $error("status not shown");
  chk_read_stable: assert property (
    @(posedge clk) disable iff (!resetn) rd_phase && chip_select && $past(chip_select) && $stable(tgl_q)
      |-> $stable(serial_out)) else $error("read bit moved without a clock rise");
  chk_read_driven: assert property (
    @(posedge clk) disable iff (!resetn) rd_phase && chip_select |-> serial_out_en) else $error("read bit not driven");
endmodule // sep_pin_if_chk

bind sep_pin_if sep_pin_if_chk #(.PROG_CYCLES(PROG_CYCLES)) i_sep_pin_if_chk (
  .clk(clk), .resetn(resetn), .serial_clock(serial_clock), .chip_select(chip_select), .serial_in(serial_in),
  .word_width_select(word_width_select), .program_allow(program_allow), .serial_out(serial_out),
  .serial_out_en(serial_out_en));

// File: test/sep_master.sv
// serial bus master model driving the memory pins
`timescale 1ns/10ps
module sep_master (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic serial_out_en,
  output logic serial_clock,
  output logic chip_select,
  output logic serial_in,
  output logic pin
);
  initial begin
    serial_clock = 1'h0;
    chip_select = 1'h0;
    serial_in = 1'h0;
  end
  // released pin has no pull: show the opposite level so a sample of a released pin is caught
  assign pin = serial_out_en ? serial_out : ~serial_out;
  // ---------------------------------------------------------------
  // link clock stands still outside these tasks
  // ---------------------------------------------------------------
  task automatic bit_io(input logic b, input int hp, input int lp, output logic seen);
    serial_in = b;
    #62.5 serial_clock = 1'h1;
    #(62.5 + hp) seen = pin;
    serial_clock = 1'h0;
    #(lp);
  endtask
  task automatic rises(input logic b, input int k);
    logic s;
    repeat (k) bit_io(b, 0, 0, s);
  endtask
  task automatic select();
    @(negedge clk);
    chip_select = 1'h1;
  endtask
  task automatic deselect();
    @(negedge clk);
    chip_select = 1'h0;
    serial_in = 1'h0;
    repeat (3) @(negedge clk);
  endtask
  // exact edge count, pauses high and low mid-frame
  task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] rx);
    logic s;
    select();
    rx = 32'h00000000;
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(bits[i], (i == 3) ? 400 : 0, (i == 7) ? 400 : 0, s);
      rx = {rx[30:0], s};
    end
  endtask
endmodule // sep_master

// File: test/sep_pin_if_tb_top.sv
// self-checking bench for the serial memory pin interface
`timescale 1ns/10ps
module sep_pin_if_tb_top;
  import sep_pkg::*;
  localparam int PROG_N = 20;
  localparam int ALL_N = 30;
  logic clk, resetn, word_width_select, program_allow;
  logic serial_clock, chip_select, serial_in, serial_out, serial_out_en, pin;
  logic [31:0] rx;
  int n_fail = 0;
  int cmp_count = 0;
  sep_pin_if #(.PROG_CYCLES(PROG_N), .ALL_CYCLES(ALL_N), .BUF_DEPTH(2)) i_sep_pin_if (
    .clk(clk), .resetn(resetn), .serial_clock(serial_clock), .chip_select(chip_select), .serial_in(serial_in),
    .word_width_select(word_width_select), .program_allow(program_allow), .serial_out(serial_out),
    .serial_out_en(serial_out_en));
  sep_master i_master (.clk(clk), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .serial_clock(serial_clock), .chip_select(chip_select), .serial_in(serial_in), .pin(pin));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // straps pass a two-stage sync on each clock, so give both a few edges
  task automatic strap(input logic w, input logic p);
    @(negedge clk);
    word_width_select = w;
    program_allow = p;
    i_master.select();
    i_master.rises(1'h0, 3);
    i_master.deselect();
  endtask
  task automatic wait_ready(input int lim, input logic busy_exp);
    repeat (7) @(negedge clk);
    if (busy_exp) check(16'(pin), 16'h0000, "busy");
    for (int i = 0; i < lim && pin !== 1'h1; i++) @(negedge clk);
    check(16'({serial_out_en, pin}), 16'h0003, "ready");
  endtask
  task automatic read16(input logic [7:0] a, input logic [15:0] exp);
    i_master.frame({5'h00, 1'h1, OP_READ, a, 16'h0000}, 27, rx);
    check(16'(rx[16]), 16'h0000, "dummy bit");
    check(rx[15:0], exp, "read word");
    i_master.deselect();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle();
    i_master.rises(1'h1, 4);
    i_master.select();
    i_master.rises(1'h0, 5);
    check(16'(serial_out_en), 16'h0000, "idle output");
    i_master.deselect();
    i_master.frame({21'h000000, 1'h1, OP_EXT, EXT_ENABLE, 6'h00}, 11, rx);
    i_master.deselect();
    $display("t_idle done");
  endtask
  task automatic t_write_read();
    i_master.frame({5'h00, 1'h1, OP_WRITE, 8'h05, 16'hA5C3}, 27, rx);
    wait_ready(PROG_N + 20, 1'h1);
    i_master.rises(1'h1, 8);
    check(16'({serial_out_en, pin}), 16'h0003, "status after extra edges");
    i_master.deselect();
    check(16'(serial_out_en), 16'h0000, "released");
    read16(8'h05, 16'hA5C3);
    $display("t_write_read done");
  endtask
  task automatic t_bytes();
    strap(1'h0, 1'h1);
    i_master.frame({12'h000, 1'h1, OP_WRITE, 9'h00B, 8'h3C}, 20, rx);
    wait_ready(PROG_N + 20, 1'h1);
    i_master.deselect();
    for (int k = 0; k < 2; k++) begin
      i_master.frame({12'h000, 1'h1, OP_READ, 8'h05, k[0], 8'h00}, 20, rx);
      check({7'h00, rx[8:0]}, k[0] ? 16'h003C : 16'h00C3, "read byte");
      i_master.deselect();
    end
    strap(1'h1, 1'h1);
    $display("t_bytes done");
  endtask
  task automatic t_inhibit();
    strap(1'h1, 1'h0);
    i_master.frame({5'h00, 1'h1, OP_WRITE, 8'h05, 16'h1234}, 27, rx);
    wait_ready(PROG_N + 20, 1'h0);
    i_master.deselect();
    read16(8'h05, 16'h3CC3);
    strap(1'h1, 1'h1);
    $display("t_inhibit done");
  endtask
  task automatic t_erall();
    i_master.frame({21'h000000, 1'h1, OP_EXT, EXT_ERALL, 6'h00}, 11, rx);
    repeat (7) @(negedge clk);
    check(16'(pin), 16'h0000, "erase all busy");
    i_master.deselect();
    repeat (20) @(negedge clk);
    i_master.select();
    wait_ready(ALL_N + 300, 1'h1);
    i_master.deselect();
    read16(8'h05, ERASED_WORD);
    $display("t_erall done");
  endtask
  // write all, single erase, then a write refused once programming is disabled
  task automatic t_all_erase();
    i_master.frame({5'h00, 1'h1, OP_EXT, EXT_WRALL, 6'h00, 16'h5A5A}, 27, rx);
    wait_ready(ALL_N + 300, 1'h1);
    i_master.deselect();
    read16(8'hF0, 16'h5A5A);
    i_master.frame({21'h000000, 1'h1, OP_ERASE, 8'h05}, 11, rx);
    wait_ready(PROG_N + 20, 1'h1);
    i_master.deselect();
    read16(8'h05, ERASED_WORD);
    read16(8'hF0, 16'h5A5A);
    i_master.frame({21'h000000, 1'h1, OP_EXT, EXT_DISABLE, 6'h00}, 11, rx);
    i_master.deselect();
    i_master.frame({5'h00, 1'h1, OP_WRITE, 8'hF0, 16'h1234}, 27, rx);
    wait_ready(PROG_N + 20, 1'h0);
    i_master.deselect();
    read16(8'hF0, 16'h5A5A);
    $display("t_all_erase done");
  endtask
  // ---------------------------------------------------------------
  // clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    resetn = 1'h0;
    word_width_select = 1'h1;
    program_allow = 1'h1;
    repeat (5) @(negedge clk);
    resetn = 1'h1;
    t_idle();
    t_write_read();
    t_bytes();
    t_inhibit();
    t_erall();
    t_all_erase();
    complete_run();
  end
  initial begin
    #2000000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule // sep_pin_if_tb_top
